// ---- conv_out_ctrl.sv ----
// Output side and mode control of a dual-channel 12-bit pipelined converter.
// Assumes the analog core offers both channel codes on sys_clk; control pins
// and the sample clock arrive asynchronously and are synchronised here.
//
// How it works
// - Each channel outputs a parallel 12-bit word.
// - Code pin low offset binary, high two's complement.
// - Two's complement inverts only the top bit.
// - Offset binary: full scale ones, zero is 800.
// - Active-low per-channel enable tri-states that channel.
// - Per-channel over-range flag, high when out of range.
// - Over-range flag shares the six-cycle data latency.
// - Below 2 MSPS power down; resume automatically above.
// - PLL enabled by default, limits rate to 20 MSPS.
// - Disabling PLL allows operation down to 2 MSPS.
// - Select pin tied low disables the register interface.
// - Low select pulse clears all registers to zero.
// - Reference pin low external, high internal buffer on.
// - Both channels sample on the same clock edge.
// - Each channel has its own data-valid output.
`timescale 1ns/1ns
module conv_out_ctrl
  import conv_out_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire logic                sample_clock,
  input  wire logic [SAMPLE_W-1:0] core_code_a,
  input  wire logic [SAMPLE_W-1:0] core_code_b,
  input  wire logic                core_over_a,
  input  wire logic                core_over_b,
  input  wire logic                output_code_select,
  input  wire logic                output_enable_a_n,
  input  wire logic                output_enable_b_n,
  input  wire logic                select_reset_n,
  input  wire logic                reference_source_select,
  input  wire logic                reg_write,
  input  wire logic                reg_pll_disable,
  input  wire logic                capture_ready,
  output logic [SAMPLE_W-1:0]      sample_a,
  output logic [SAMPLE_W-1:0]      sample_b,
  output logic                     sample_a_oe,
  output logic                     sample_b_oe,
  output logic                     over_range_a,
  output logic                     over_range_b,
  output logic                     sample_valid_a,
  output logic                     sample_valid_b,
  output logic                     power_down,
  output logic                     pll_rate_fault,
  output logic                     pll_disabled,
  output logic                     internal_reference_on,
  output logic                     sample_dropped
);

  // ****************************************************************
  // Coding
  // ****************************************************************
  // Both codings differ only in the top bit.
  function automatic logic [SAMPLE_W-1:0] apply_coding(input logic [SAMPLE_W-1:0] code,
                                                       input logic              twos);
    apply_coding = {code[TOP_BIT] ^ twos, code[TOP_BIT-1:0]};
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic [SYNC_W-1:0] sync3;
  logic [SYNC_W-1:0] pin_stable;
  logic [SYNC_W-1:0] pin_agree;

  assign pin_raw = {sample_clock, reference_source_select, select_reset_n,
                    output_enable_b_n, output_enable_a_n, output_code_select};
  assign pin_agree = ~(sync2 ^ sync3);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync1      <= PIN_RESET;
      sync2      <= PIN_RESET;
      sync3      <= PIN_RESET;
      pin_stable <= PIN_RESET;
    end else begin
      sync1      <= pin_raw;
      sync2      <= sync1;
      sync3      <= sync2;
      pin_stable <= (sync3 & pin_agree) | (pin_stable & ~pin_agree);
    end
  end

  // ****************************************************************
  // Register interface
  // ****************************************************************
  logic pll_disable;

  always_ff @(posedge sys_clk) begin
    if (rst || !pin_stable[PIN_SEL]) begin
      pll_disable <= PLL_DISABLE_RESET;
    end else if (reg_write) begin
      pll_disable <= reg_pll_disable;
    end
  end

  // ****************************************************************
  // Sample clock rate monitor
  // ****************************************************************
  logic                sclk_prev;
  logic                conv_edge;
  logic [PERIOD_W-1:0] period_cnt;
  logic                rate_ok;
  logic                pll_ok;
  logic                accept;

  assign conv_edge = pin_stable[PIN_SCLK] && !sclk_prev;
  assign rate_ok   = (period_cnt <= LOW_RATE_CNT);
  assign pll_ok    = pll_disable || (period_cnt <= PLL_MIN_CNT);
  assign accept    = conv_edge && rate_ok && pll_ok;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sclk_prev  <= 1'b0;
      period_cnt <= PERIOD_MAX;
    end else begin
      sclk_prev <= pin_stable[PIN_SCLK];
      if (conv_edge) begin
        period_cnt <= PERIOD_W'(1);
      end else if (period_cnt != PERIOD_MAX) begin
        period_cnt <= period_cnt + PERIOD_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      power_down     <= 1'b1;
      pll_rate_fault <= 1'b0;
    end else begin
      if (!rate_ok) begin
        power_down <= 1'b1;
      end else if (conv_edge) begin
        power_down <= 1'b0;
      end
      if (conv_edge) begin
        pll_rate_fault <= rate_ok && !pll_ok;
      end
    end
  end

  // ****************************************************************
  // Conversion pipeline
  // ****************************************************************
  // Word layout: {valid, over_b, code_b, over_a, code_a}, both channels
  // taken on the same edge and advanced together.
  logic [WORD_W-1:0] pipe [PIPE_DEPTH];
  logic              push_pending;
  logic [WORD_W-1:0] push_word;

  sample_stream_if #(.WIDTH(WORD_W)) stream ();

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < PIPE_DEPTH; i++) begin
        pipe[i] <= '0;
      end
    end else if (conv_edge) begin
      pipe[0] <= {accept, core_over_b, core_code_b, core_over_a, core_code_a};
      for (int i = 1; i < PIPE_DEPTH; i++) begin
        pipe[i] <= pipe[i-1];
      end
    end else if (power_down) begin
      for (int i = 0; i < PIPE_DEPTH; i++) begin
        pipe[i][VALID_BIT] <= 1'b0;
      end
    end
  end

  // The oldest stage is offered once, on the cycle after the edge that retires it.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      push_pending <= 1'b0;
      push_word    <= '0;
    end else begin
      push_pending <= conv_edge && pipe[PIPE_DEPTH-1][VALID_BIT];
      if (conv_edge) begin
        push_word <= pipe[PIPE_DEPTH-1];
      end
    end
  end

  assign stream.in_valid = push_pending;
  assign stream.in_data  = push_word;

  // A full buffer cannot stall the converter, so the word is lost and flagged.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sample_dropped <= 1'b0;
    end else begin
      sample_dropped <= push_pending && !stream.in_ready;
    end
  end

  sample_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) sample_fifo_i (
    .sys_clk (sys_clk),
    .rst     (rst),
    .port    (stream.buffer)
  );

  // ****************************************************************
  // Output stage
  // ****************************************************************
  logic              out_full;
  logic              out_load;
  logic [WORD_W-1:0] pop_word;
  logic              twos;

  assign pop_word         = stream.out_data;
  assign out_load         = stream.out_valid && (!out_full || capture_ready);
  assign stream.out_ready = out_load;
  assign twos             = pin_stable[PIN_CODE];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      out_full <= 1'b0;
    end else if (out_load) begin
      out_full <= 1'b1;
    end else if (capture_ready) begin
      out_full <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sample_a     <= '0;
      sample_b     <= '0;
      over_range_a <= 1'b0;
      over_range_b <= 1'b0;
    end else if (out_load) begin
      sample_a     <= apply_coding(pop_word[SAMPLE_W-1:0], twos);
      sample_b     <= apply_coding(pop_word[SLOT_B_LSB +: SAMPLE_W], twos);
      over_range_a <= pop_word[SAMPLE_W];
      over_range_b <= pop_word[SLOT_B_LSB + SAMPLE_W];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sample_valid_a <= 1'b0;
      sample_valid_b <= 1'b0;
    end else if (out_load) begin
      sample_valid_a <= !pin_stable[PIN_OE_A];
      sample_valid_b <= !pin_stable[PIN_OE_B];
    end else if (capture_ready) begin
      sample_valid_a <= 1'b0;
      sample_valid_b <= 1'b0;
    end
  end

  // ****************************************************************
  // Output enables and reference select
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sample_a_oe <= 1'b0;
      sample_b_oe <= 1'b0;
    end else begin
      sample_a_oe <= !pin_stable[PIN_OE_A];
      sample_b_oe <= !pin_stable[PIN_OE_B];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      internal_reference_on <= 1'b0;
      pll_disabled          <= 1'b0;
    end else begin
      internal_reference_on <= pin_stable[PIN_REF];
      pll_disabled          <= pll_disable;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence ref_held_high;
    reference_source_select [*6];
  endsequence

  sequence ref_held_low;
    !reference_source_select [*6];
  endsequence

  sequence enable_a_held;
    !output_enable_a_n [*6];
  endsequence

  ref_internal_a: assert property (ref_held_high |=> internal_reference_on)
    else $error("Internal reference not selected after pin held high.");
  ref_external_a: assert property (ref_held_low |=> !internal_reference_on)
    else $error("Internal reference buffer still on after pin held low.");
  enable_a_drive_a: assert property (enable_a_held |=> sample_a_oe)
    else $error("Channel A not driven while enable held low.");
  enable_b_off_a: assert property (output_enable_b_n [*6] |=> !sample_b_oe)
    else $error("Channel B still driven while enable held high.");
  sel_clears_a: assert property (!pin_stable[PIN_SEL] |=> !pll_disable ##1 !pll_disabled)
    else $error("PLL disable bit not cleared by select low.");
  write_blocked_a: assert property (!pin_stable[PIN_SEL] && reg_write |=> !pll_disable)
    else $error("Register write taken while interface disabled.");
  low_rate_a: assert property (period_cnt > LOW_RATE_CNT |=> power_down)
    else $error("No power-down on slow sample clock.");
  resume_a: assert property (conv_edge && rate_ok |=> !power_down)
    else $error("No automatic resume on fast sample clock.");
  pll_limit_a: assert property (conv_edge && !pll_disable && period_cnt > PLL_MIN_CNT
                                && rate_ok |=> !pipe[0][VALID_BIT] && pll_rate_fault)
    else $error("Sample taken below PLL minimum rate.");
  pll_off_a: assert property (conv_edge && pll_disable && rate_ok |=> pipe[0][VALID_BIT])
    else $error("Sample refused with PLL disabled.");
  code_msb_a: assert property (out_load ##1 1'b1 |-> sample_a[TOP_BIT-1:0]
                               == $past(pop_word[TOP_BIT-1:0])
                               && sample_a[TOP_BIT] == ($past(pop_word[TOP_BIT]) ^ $past(twos)))
    else $error("Channel A coding differs beyond the top bit.");
  over_align_a: assert property (out_load |=> over_range_b == $past(pop_word[WORD_W-2]))
    else $error("Over-range flag out of step with its word.");

endmodule // conv_out_ctrl

// ---- conv_out_pkg.sv ----
// Shared constants for the dual-channel converter output and mode control.
// Assumes one 125 MHz system clock and a synchronous active-high reset.
package conv_out_pkg;

  // ****************************************************************
  // Widths and depths
  // ****************************************************************
  localparam int SAMPLE_W   = 12;
  localparam int TOP_BIT    = 11;
  localparam int PIPE_DEPTH = 6;
  localparam int FIFO_DEPTH = 16;
  // One channel slot is {over-range, code}; a word holds both channels.
  localparam int SLOT_W     = SAMPLE_W + 1;
  localparam int WORD_W     = 2 * SLOT_W + 1;
  localparam int VALID_BIT  = WORD_W - 1;
  localparam int SLOT_B_LSB = SLOT_W;
  localparam int SYNC_W     = 6;

  // ****************************************************************
  // Synchronised pin positions
  // ****************************************************************
  localparam int PIN_CODE   = 0;
  localparam int PIN_OE_A   = 1;
  localparam int PIN_OE_B   = 2;
  localparam int PIN_SEL    = 3;
  localparam int PIN_REF    = 4;
  localparam int PIN_SCLK   = 5;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [SYNC_W-1:0] PIN_RESET         = 6'h00;
  localparam logic              PLL_DISABLE_RESET = 1'b0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS     = 8;
  localparam int LOW_RATE_PERIOD_NS = 500;
  localparam int PLL_MIN_PERIOD_NS = 50;
  localparam int LOW_RATE_CYCLES   = LOW_RATE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PLL_MIN_CYCLES    = PLL_MIN_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PERIOD_W          = 8;
  localparam logic [PERIOD_W-1:0] LOW_RATE_CNT = PERIOD_W'(LOW_RATE_CYCLES);
  localparam logic [PERIOD_W-1:0] PLL_MIN_CNT  = PERIOD_W'(PLL_MIN_CYCLES);
  localparam logic [PERIOD_W-1:0] PERIOD_MAX   = 8'hFF;

endpackage

// ---- sample_stream_if.sv ----
// Valid/ready stream of converted sample words between the control logic
// and its output buffer. Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface sample_stream_if #(parameter int WIDTH = 8);
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;

  modport buffer (input in_valid, input in_data, output in_ready,
                  output out_valid, output out_data, input out_ready);
  modport user   (output in_valid, output in_data, input in_ready,
                  input out_valid, input out_data, output out_ready);
endinterface

// ---- sample_fifo.sv ----
// First-in first-out buffer for sample words, width and depth as parameters.
// Assumes a synchronous active-high reset on the shared system clock.
`timescale 1ns/1ns
module sample_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic           sys_clk,
  input  wire logic           rst,
  sample_stream_if.buffer     port
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  assign full          = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty         = (wr_ptr == rd_ptr);
  assign port.in_ready  = !full;
  assign port.out_valid = !empty;
  assign port.out_data  = store[rd_ptr[AW-1:0]];
  assign push          = port.in_valid && !full;
  assign pop           = port.out_ready && !empty;

  always_ff @(posedge sys_clk) begin
    if (push) begin
      store[wr_ptr[AW-1:0]] <= port.in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + (AW+1)'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + (AW+1)'(1);
      end
    end
  end

endmodule // sample_fifo

// ---- capture_model.sv ----
// Capture logic model fed by the converter's parallel outputs.
// Assumes the design's system clock; rst is synchronous, active high.
`timescale 1ns/1ns
module capture_model
  import conv_out_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire logic                output_code_select,
  input  wire logic                stall,
  input  wire logic                slow,
  input  wire logic                power_down,
  input  wire logic [SAMPLE_W-1:0] sample_a,
  input  wire logic [SAMPLE_W-1:0] sample_b,
  input  wire logic                over_range_a,
  input  wire logic                over_range_b,
  input  wire logic                sample_valid_a,
  input  wire logic                sample_valid_b,
  output logic                     capture_ready,
  output int                       words,
  output int                       bad,
  output int                       gaps,
  output logic [SAMPLE_W-1:0]      last_a
);
  // ****************************************************************
  // Capture and pairing checks
  // ****************************************************************
  logic [SAMPLE_W-1:0] raw_a, raw_b, prev;
  logic                first, flip;

  // Undoing the coding lets both codings be judged by one raw order.
  assign raw_a = sample_a ^ {output_code_select, {TOP_BIT{1'b0}}};
  assign raw_b = sample_b ^ {output_code_select, {TOP_BIT{1'b0}}};

  initial capture_ready = 1'b0;

  always @(posedge sys_clk) begin
    if (rst) begin
      words = 0;
      bad = 0;
      gaps = 0;
      first = 1'b1;
      flip = 1'b0;
    end else begin
      // Words in flight are lost in a low-rate stop, so ordering restarts.
      if (power_down)
        first = 1'b1;
      if (capture_ready && sample_valid_a && sample_valid_b) begin
        words++;
        last_a = sample_a;
        if (raw_b !== ~raw_a || over_range_a !== raw_a[0] || over_range_b !== raw_b[0])
          bad++;
        if (!first && raw_a !== prev + 12'h001)
          gaps++;
        prev = raw_a;
        first = 1'b0;
      end
      flip = ~flip;
    end
    #1;
    capture_ready = !stall && (!slow || flip);
  end
endmodule // capture_model

// ---- tb.sv ----
// Self-checking bench for the converter output control with a capture model.
// Assumes conv_out_pkg, the stream interface, the buffer and capture_model.
`timescale 1ns/1ns
module tb;
  import conv_out_pkg::*;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic                sys_clk, rst, sample_clock, output_code_select, reg_write;
  logic                output_enable_a_n, output_enable_b_n, select_reset_n;
  logic                reference_source_select, reg_pll_disable, capture_ready;
  logic                core_over_a, core_over_b, sample_a_oe, sample_b_oe;
  logic                over_range_a, over_range_b, sample_valid_a, sample_valid_b;
  logic                power_down, pll_rate_fault, pll_disabled, internal_reference_on;
  logic                sample_dropped, stall, slow, fixed, va, vb, dropped;
  logic [SAMPLE_W-1:0] core_code_a, core_code_b, sample_a, sample_b, last_a;
  int                  k, words, bad, gaps, n_mismatch, samples_checked, w0, g0;

  conv_out_ctrl conv_out_ctrl_i (.*);
  capture_model capture_model_i (.*);

  assign core_code_b = ~core_code_a;
  assign core_over_a = core_code_a[0];
  assign core_over_b = core_code_b[0];

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task chk(string what, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task tick(int n);
    repeat (n) begin
      @(posedge sys_clk);
      #1;
      va |= sample_valid_a;
      vb |= sample_valid_b;
      dropped |= sample_dropped;
    end
  endtask

  task conv(int n, int half);
    repeat (n) begin
      sample_clock = 1'b1;
      k++;
      if (!fixed)
        core_code_a = 12'h100 + 12'(k);
      tick(half);
      sample_clock = 1'b0;
      tick(half);
    end
  endtask

  task drain;
    tick(4);
    for (int i = 0; i < 400 && sample_valid_b; i++)
      tick(1);
    if (sample_valid_b) begin
      n_mismatch++;
      $display("[FAIL] output buffer never emptied");
      end_of_test;
    end
    // Let the rate monitor power down so the next scenario starts afresh.
    tick(LOW_RATE_CYCLES + 8);
  endtask

  task wreg(logic d);
    reg_pll_disable = d;
    reg_write = 1'b1;
    tick(1);
    reg_write = 1'b0;
    tick(1);
  endtask

  task end_of_test;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_stream;
    w0 = words;
    g0 = gaps;
    conv(20, 3);
    slow = 1'b1;
    conv(20, 3);
    slow = 1'b0;
    drain;
    chk("pairing", 32'(bad), 32'h0);
    chk("order", 32'(gaps - g0), 32'h0);
    chk("words", 32'(words - w0 >= 25), 32'h1);
    $display("stream test done");
  endtask

  task t_fill;
    w0 = words;
    g0 = gaps;
    dropped = 1'b0;
    stall = 1'b1;
    conv(30, 3);
    chk("held valid", 32'(sample_valid_a), 32'h1);
    chk("dropped", 32'(dropped), 32'h1);
    stall = 1'b0;
    drain;
    chk("buffered", 32'(words - w0 >= FIFO_DEPTH), 32'h1);
    chk("order", 32'(gaps - g0), 32'h0);
    $display("fill test done");
  endtask

  task t_coding;
    static logic [SAMPLE_W-1:0] lvl [5] = '{12'hFFF, 12'hC00, 12'h800, 12'h400, 12'h000};
    fixed = 1'b1;
    for (int t = 0; t < 2; t++) begin
      output_code_select = t[0];
      for (int i = 0; i < 5; i++) begin
        core_code_a = lvl[i];
        conv(10, 3);
        tick(4);
        chk("code", 32'(last_a), 32'({t[0], 11'h000} ^ lvl[i]));
      end
    end
    output_code_select = 1'b0;
    fixed = 1'b0;
    chk("pairing", 32'(bad), 32'h0);
    $display("coding test done");
  endtask

  task t_enable;
    for (int ch = 0; ch < 2; ch++) begin
      output_enable_a_n = (ch == 0);
      output_enable_b_n = (ch == 1);
      tick(8);
      chk("oe", 32'({sample_a_oe, sample_b_oe}), (ch == 0) ? 32'h1 : 32'h2);
      va = 1'b0;
      vb = 1'b0;
      conv(12, 3);
      chk("valid", 32'({va, vb}), (ch == 0) ? 32'h1 : 32'h2);
      drain;
    end
    output_enable_b_n = 1'b0;
    tick(8);
    chk("oe", 32'({sample_a_oe, sample_b_oe}), 32'h3);
    $display("enable test done");
  endtask

  task t_power;
    tick(80);
    chk("power down", 32'(power_down), 32'h1);
    conv(4, 3);
    chk("resume", 32'(power_down), 32'h0);
    conv(3, 30);
    chk("slow run", 32'(power_down), 32'h0);
    chk("pll fault", 32'(pll_rate_fault), 32'h1);
    $display("power test done");
  endtask

  task t_pll;
    conv(8, 4);
    tick(4);
    w0 = words;
    conv(8, 4);
    tick(4);
    chk("pll fault", 32'(pll_rate_fault), 32'h1);
    chk("refused", 32'(words - w0), 32'h0);
    wreg(1'b1);
    chk("pll off", 32'(pll_disabled), 32'h1);
    w0 = words;
    conv(12, 4);
    tick(4);
    chk("pll fault", 32'(pll_rate_fault), 32'h0);
    chk("accepted", 32'(words - w0), 32'(12 - PIPE_DEPTH));
    select_reset_n = 1'b0;
    tick(8);
    chk("cleared", 32'(pll_disabled), 32'h0);
    wreg(1'b1);
    tick(2);
    chk("blocked", 32'(pll_disabled), 32'h0);
    select_reset_n = 1'b1;
    tick(8);
    $display("pll test done");
  endtask

  task t_ref;
    for (int v = 1; v >= 0; v--) begin
      reference_source_select = v[0];
      tick(6);
      chk("reference", 32'(internal_reference_on), 32'(v));
    end
    $display("reference test done");
  endtask

  initial begin
    rst = 1'b1;
    sample_clock = 1'b0;
    core_code_a = 12'h000;
    output_code_select = 1'b0;
    output_enable_a_n = 1'b0;
    output_enable_b_n = 1'b0;
    select_reset_n = 1'b0;
    reference_source_select = 1'b0;
    reg_write = 1'b0;
    reg_pll_disable = 1'b0;
    {stall, slow, fixed, va, vb, dropped} = 6'h00;
    k = 0;
    n_mismatch = 0;
    samples_checked = 0;
    tick(2);
    rst = 1'b0;
    select_reset_n = 1'b1;
    chk("reset pd", 32'(power_down), 32'h1);
    chk("reset pll", 32'(pll_disabled), 32'h0);
    chk("reset valid", 32'({sample_valid_a, sample_valid_b}), 32'h0);
    $display("reset test done");
    tick(8);
    t_stream;
    t_fill;
    t_coding;
    t_enable;
    t_power;
    t_pll;
    t_ref;
    end_of_test;
  end
endmodule // tb
